// file: src/mct_pkg.sv
// Purpose: shared constants and types of the match/capture counter-timer block
// Assumes: 32-bit apb data, byte addresses, one aligned word per register
// Notes: timers 0 and 1 are 32 bits wide, timers 2 and 3 are 16 bits wide
package mct_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int MCT_NTMR = 4;
  localparam int MCT_NMR = 4;
  localparam int MCT_NCAP_PINS = 5;
  localparam int MCT_AW = 12;
  // per timer: counter mask, capture pins, first capture pin
  localparam logic [3:0][31:0] MCT_TC_MASK = {32'h0000FFFF, 32'h0000FFFF,
                                              32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [3:0][2:0] MCT_NCAP = {3'h1, 3'h1, 3'h1, 3'h2};
  localparam logic [3:0][2:0] MCT_CAP_BASE = {3'h4, 3'h3, 3'h2, 3'h0};

  // ************************************************************
  // register map: per-timer block at timer*0x40, shared block at 0x100
  // ************************************************************
  localparam logic [1:0] MCT_SEL_TMR = 2'h0;
  localparam logic [1:0] MCT_SEL_GLB = 2'h1;
  localparam logic [3:0] MCT_R_CTRL = 4'h0;
  localparam logic [3:0] MCT_R_COUNT = 4'h1;
  localparam logic [3:0] MCT_R_PSTERM = 4'h2;
  localparam logic [3:0] MCT_R_PSCNT = 4'h3;
  localparam logic [3:0] MCT_R_MACT = 4'h4;
  localparam logic [3:0] MCT_R_MVAL0 = 4'h5;
  localparam logic [3:0] MCT_R_EXTOUT = 4'h9;
  localparam logic [3:0] MCT_R_CAPCTL = 4'hA;
  localparam logic [3:0] MCT_R_CAPVAL0 = 4'hB;
  localparam logic [3:0] MCT_R_CAPVAL1 = 4'hC;
  localparam logic [3:0] MCT_R_CLRCTL = 4'hD;
  localparam logic [3:0] MCT_R_ISTAT = 4'h0;
  localparam logic [3:0] MCT_R_ICLR = 4'h1;
  localparam logic [3:0] MCT_R_IEN = 4'h2;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int MCT_CTRL_EN = 0;
  localparam int MCT_CTRL_RST = 1;
  localparam int MCT_MACT_INT = 0;
  localparam int MCT_MACT_RST = 1;
  localparam int MCT_MACT_STOP = 2;
  localparam int MCT_CAP_RISE = 0;
  localparam int MCT_CAP_FALL = 1;
  localparam int MCT_CAP_INT = 2;
  localparam int MCT_CLR_EN = 0;
  localparam int MCT_CLR_FALL = 1;
  localparam int MCT_CLR_CH = 2;
  localparam int MCT_EXT_ACT = 4;
  localparam int MCT_IST_CAP = 4;
  localparam logic [31:0] MCT_RST_ZERO = 32'h00000000;

  typedef enum logic [1:0] {
    MCT_EXT_NONE = 2'h0,
    MCT_EXT_LOW = 2'h1,
    MCT_EXT_HIGH = 2'h2,
    MCT_EXT_TOGGLE = 2'h3
  } mct_ext_e;

  typedef struct packed {
    logic en;
    logic crst;
    logic [31:0] tc;
    logic [31:0] pc;
    logic [31:0] pr;
    logic [11:0] mact;
    logic [3:0][31:0] mr;
    logic [3:0] mprev;
    logic [3:0] ext;
    logic [7:0] extact;
    logic [5:0] capctl;
    logic [1:0][31:0] cr;
    logic [2:0] clrctl;
  } mct_tmr_s;

  typedef struct packed {
    mct_tmr_s [3:0] tmr;
    logic [31:0] istat;
    logic [31:0] ien;
    logic [31:0] prdata;
  } mct_state_s;

  typedef struct packed {
    logic [3:0] wide0;
    logic [3:0] wide1;
    logic [2:0] narrow0;
    logic [1:0] narrow1;
  } mct_match_s;

endpackage : mct_pkg

// file: src/mct_sync.sv
// Purpose: two-flop synchroniser with edge detection for capture pins
// Assumes: inputs are asynchronous to pclk
// Notes: edges are reported in the same cycle as the synchronised level changes
`timescale 1ns/100ps
module mct_sync
  import mct_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  // [0] first stage, [1] second stage, [2] history for edges
  logic [2:0][W-1:0] st_reg;
  logic [2:0][W-1:0] st_next;

  always_comb begin
    st_next = {st_reg[1], st_reg[0], din};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // only the second stage and the history are looked at
  assign rise = st_reg[1] & ~st_reg[2];
  assign fall = ~st_reg[1] & st_reg[2];

endmodule : mct_sync

// file: src/mct_timer.sv
// Function
// - each timer has four match registers compared with its counter
// - a match may leave the counter running and interrupts only when enabled
// - a match may stop the counter, optionally interrupting
// - a match may reset the counter to zero, optionally interrupting
// - up to four match output pins per timer, one per match register
// - on match an output goes low, high, toggles or stays
// - a chosen capture edge can clear counter and prescaler
// - clear on leading edge, capture counter on trailing edge for pulse width
// - wide timer zero drives match outputs zero to three
// - wide timer zero takes capture inputs zero and one
// - narrow timer zero takes capture input zero
// - four timers, five capture inputs, thirteen match outputs in total
//
// Purpose: four counter/timers with match and capture behind an apb slave
// Assumes: pclk 25 MHz, apb master per protocol, capture pins asynchronous
// Notes: zero-wait apb; unmapped addresses answer with pslverr
`timescale 1ns/100ps
module mct_timer
  import mct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MCT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic wide_timer0_capture_in0,
  input wire logic wide_timer0_capture_in1,
  input wire logic wide_timer1_capture_in0,
  input wire logic narrow_timer0_capture_in0,
  input wire logic narrow_timer1_capture_in0,
  output logic wide_timer0_match_out0,
  output logic wide_timer0_match_out1,
  output logic wide_timer0_match_out2,
  output logic wide_timer0_match_out3,
  output logic [3:0] wide_timer1_match_out,
  output logic [2:0] narrow_timer0_match_out,
  output logic [1:0] narrow_timer1_match_out
);

  // ************************************************************
  // capture pin synchronisation
  // ************************************************************
  logic [MCT_NCAP_PINS-1:0] cap_pins;
  logic [MCT_NCAP_PINS-1:0] cap_rise;
  logic [MCT_NCAP_PINS-1:0] cap_fall;
  logic [7:0] rise8;
  logic [7:0] fall8;

  assign cap_pins = {narrow_timer1_capture_in0, narrow_timer0_capture_in0,
                     wide_timer1_capture_in0,
                     wide_timer0_capture_in1, wide_timer0_capture_in0};

  mct_sync #(.W(MCT_NCAP_PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(cap_pins),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  assign rise8 = {3'h0, cap_rise};
  assign fall8 = {3'h0, cap_fall};

  // ************************************************************
  // state and event decode
  // ************************************************************
  mct_state_s st_reg;
  mct_state_s st_next;
  logic [3:0][3:0] mevt;
  logic [3:0][1:0] crise;
  logic [3:0][1:0] cfall;
  logic [3:0] tick;
  logic [3:0] cclr;
  logic [3:0] mrst;
  logic [3:0] mstop;
  logic [31:0] iset;
  logic [31:0] rdata;
  logic rmapped;
  logic setup;
  logic wr_acc;
  logic [1:0] tsel;
  logic [3:0] ridx;
  logic [1:0] blk;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign tsel = paddr[7:6];
  assign ridx = paddr[5:2];
  assign blk = {1'b0, paddr[8]};

  // read decode of the addressed word
  always_comb begin
    rdata = MCT_RST_ZERO;
    rmapped = 1'b1;
    if (paddr[MCT_AW-1:9] != '0) begin
      rmapped = 1'b0;
    end else if (blk == MCT_SEL_GLB) begin
      if (paddr[7:6] != 2'h0) begin
        rmapped = 1'b0;
      end else if (ridx == MCT_R_ISTAT) begin
        rdata = st_reg.istat;
      end else if (ridx == MCT_R_IEN) begin
        rdata = st_reg.ien;
      end else if (ridx != MCT_R_ICLR) begin
        rmapped = 1'b0;
      end
    end else begin
      unique case (ridx)
        MCT_R_CTRL: rdata = {30'h0, st_reg.tmr[tsel].crst, st_reg.tmr[tsel].en};
        MCT_R_COUNT: rdata = st_reg.tmr[tsel].tc;
        MCT_R_PSTERM: rdata = st_reg.tmr[tsel].pr;
        MCT_R_PSCNT: rdata = st_reg.tmr[tsel].pc;
        MCT_R_MACT: rdata = {20'h0, st_reg.tmr[tsel].mact};
        4'h5, 4'h6, 4'h7, 4'h8: rdata = st_reg.tmr[tsel].mr[ridx[1:0] - 2'h1];
        MCT_R_EXTOUT: rdata = {20'h0, st_reg.tmr[tsel].extact, st_reg.tmr[tsel].ext};
        MCT_R_CAPCTL: rdata = {26'h0, st_reg.tmr[tsel].capctl};
        MCT_R_CAPVAL0: rdata = st_reg.tmr[tsel].cr[0];
        MCT_R_CAPVAL1: rdata = st_reg.tmr[tsel].cr[1];
        MCT_R_CLRCTL: rdata = {29'h0, st_reg.tmr[tsel].clrctl};
        default: rmapped = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    mct_tmr_s tm;
    logic eq;
    logic [2:0] ci;
    tm = '0;
    eq = 1'b0;
    ci = 3'h0;
    st_next = st_reg;
    mevt = '0;
    crise = '0;
    cfall = '0;
    tick = '0;
    cclr = '0;
    mrst = '0;
    mstop = '0;
    iset = '0;
    for (int t = 0; t < MCT_NTMR; t++) begin
      tm = st_reg.tmr[t];
      for (int c = 0; c < 2; c++) begin
        ci = MCT_CAP_BASE[t] + 3'(c);
        crise[t][c] = (3'(c) < MCT_NCAP[t]) && rise8[ci];
        cfall[t][c] = (3'(c) < MCT_NCAP[t]) && fall8[ci];
      end
      // chosen edge on chosen channel clears counter and prescaler
      cclr[t] = tm.clrctl[MCT_CLR_EN] && (tm.clrctl[MCT_CLR_FALL] ?
                cfall[t][tm.clrctl[MCT_CLR_CH]] : crise[t][tm.clrctl[MCT_CLR_CH]]);
      tick[t] = tm.en && !tm.crst && (tm.pc == tm.pr);
      // edge-qualified compare so a prescaled count held for many clocks acts once
      for (int i = 0; i < MCT_NMR; i++) begin
        eq = (tm.tc & MCT_TC_MASK[t]) == (tm.mr[i] & MCT_TC_MASK[t]);
        mevt[t][i] = eq && !tm.mprev[i];
        st_next.tmr[t].mprev[i] = eq;
        if (mevt[t][i]) begin
          mrst[t] = mrst[t] | tm.mact[3*i+MCT_MACT_RST];
          mstop[t] = mstop[t] | tm.mact[3*i+MCT_MACT_STOP];
          iset[8*t+i] = tm.mact[3*i+MCT_MACT_INT];
          unique case (mct_ext_e'(tm.extact[2*i+:2]))
            MCT_EXT_NONE: st_next.tmr[t].ext[i] = tm.ext[i];
            MCT_EXT_LOW: st_next.tmr[t].ext[i] = 1'b0;
            MCT_EXT_HIGH: st_next.tmr[t].ext[i] = 1'b1;
            MCT_EXT_TOGGLE: st_next.tmr[t].ext[i] = ~tm.ext[i];
          endcase
        end
      end
      if (tm.crst || cclr[t] || mrst[t]) begin
        st_next.tmr[t].tc = '0;
        st_next.tmr[t].pc = '0;
      end else if (tick[t]) begin
        st_next.tmr[t].pc = '0;
        st_next.tmr[t].tc = (tm.tc + 32'h1) & MCT_TC_MASK[t];
      end else if (tm.en) begin
        st_next.tmr[t].pc = tm.pc + 32'h1;
      end
      if (mstop[t]) begin
        st_next.tmr[t].en = 1'b0;
      end
      for (int c = 0; c < 2; c++) begin
        if ((tm.capctl[3*c+MCT_CAP_RISE] && crise[t][c]) ||
            (tm.capctl[3*c+MCT_CAP_FALL] && cfall[t][c])) begin
          st_next.tmr[t].cr[c] = tm.tc;
          iset[8*t+MCT_IST_CAP+c] = tm.capctl[3*c+MCT_CAP_INT];
        end
      end
    end
    if (setup) begin
      st_next.prdata = rdata;
    end
    // software writes override the counter's own update of the same cycle
    if (wr_acc && paddr[MCT_AW-1:9] == '0) begin
      if (blk == MCT_SEL_TMR) begin
        unique case (ridx)
          MCT_R_CTRL: begin
            st_next.tmr[tsel].en = pwdata[MCT_CTRL_EN];
            st_next.tmr[tsel].crst = pwdata[MCT_CTRL_RST];
          end
          MCT_R_PSTERM: st_next.tmr[tsel].pr = pwdata;
          MCT_R_MACT: st_next.tmr[tsel].mact = pwdata[11:0];
          4'h5, 4'h6, 4'h7, 4'h8: st_next.tmr[tsel].mr[ridx[1:0] - 2'h1] = pwdata;
          MCT_R_EXTOUT: begin
            st_next.tmr[tsel].ext = pwdata[3:0];
            st_next.tmr[tsel].extact = pwdata[MCT_EXT_ACT+:8];
          end
          MCT_R_CAPCTL: st_next.tmr[tsel].capctl = pwdata[5:0];
          MCT_R_CLRCTL: st_next.tmr[tsel].clrctl = pwdata[2:0];
          default: ;
        endcase
      end else if (paddr[7:6] == 2'h0 && ridx == MCT_R_IEN) begin
        st_next.ien = pwdata;
      end
    end
    // a new event in the cycle of its clear stays set
    st_next.istat = st_reg.istat | iset;
    if (wr_acc && blk == MCT_SEL_GLB && paddr[7:6] == 2'h0 && ridx == MCT_R_ICLR &&
        paddr[MCT_AW-1:9] == '0) begin
      st_next.istat = (st_reg.istat & ~pwdata) | iset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  mct_match_s mout;

  assign mout = {st_reg.tmr[0].ext, st_reg.tmr[1].ext,
                 st_reg.tmr[2].ext[2:0], st_reg.tmr[3].ext[1:0]};
  assign wide_timer0_match_out0 = mout.wide0[0];
  assign wide_timer0_match_out1 = mout.wide0[1];
  assign wide_timer0_match_out2 = mout.wide0[2];
  assign wide_timer0_match_out3 = mout.wide0[3];
  assign wide_timer1_match_out = mout.wide1;
  assign narrow_timer0_match_out = mout.narrow0;
  assign narrow_timer1_match_out = mout.narrow1;
  assign prdata = st_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rmapped;
  assign irq = |(st_reg.istat & st_reg.ien);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_match_int;
    mevt[0][1] && st_reg.tmr[0].mact[3+MCT_MACT_INT] |=> st_reg.istat[1];
  endproperty
  a_match_int: assert property (p_match_int) else $error("match interrupt not raised");

  property p_no_int;
    mevt[0][0] && !st_reg.tmr[0].mact[MCT_MACT_INT] && !st_reg.istat[0] && !iset[0]
      |=> !st_reg.istat[0];
  endproperty
  a_no_int: assert property (p_no_int) else $error("match interrupt without enable");

  property p_stop;
    mevt[0][0] && st_reg.tmr[0].mact[MCT_MACT_STOP] && !wr_acc |=> !st_reg.tmr[0].en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop on match failed");

  property p_reset;
    mevt[1][0] && st_reg.tmr[1].mact[MCT_MACT_RST]
      |=> st_reg.tmr[1].tc == 32'h0 && st_reg.tmr[1].pc == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset on match failed");

  property p_toggle;
    mevt[0][2] && st_reg.tmr[0].extact[5:4] == MCT_EXT_TOGGLE && !wr_acc
      |=> wide_timer0_match_out2 != $past(wide_timer0_match_out2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match output did not toggle");

  property p_clear;
    cclr[2] |=> st_reg.tmr[2].tc == 32'h0 && st_reg.tmr[2].pc == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("capture clear failed");

  property p_capture;
    crise[0][1] && st_reg.tmr[0].capctl[3+MCT_CAP_RISE]
      |=> st_reg.tmr[0].cr[1] == $past(st_reg.tmr[0].tc);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_tick;
    tick[0] && !cclr[0] && !mrst[0] && !wr_acc
      |=> st_reg.tmr[0].tc == $past(st_reg.tmr[0].tc) + 32'h1 && st_reg.tmr[0].pc == 32'h0;
  endproperty
  a_tick: assert property (p_tick) else $error("counter did not step on wrap");

  property p_narrow;
    st_reg.tmr[2].tc[31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow counter exceeds 16 bits");

endmodule : mct_timer

// file: tb/mct_pins_model.sv
// Purpose: far-side model driving the five capture pins
// Assumes: one pulse requested at a time
// Notes: pins idle low and change just after a rising edge
`timescale 1ns/100ps
module mct_pins_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic [7:0] len,
  output logic [4:0] cap,
  output logic busy
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 5'h00;
      cnt <= 8'h00;
      busy <= 1'b0;
    end else if (go) begin
      cap[sel] <= 1'b1;
      cnt <= len;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) begin
        cap <= 5'h00;
        busy <= 1'b0;
      end
    end
  end
endmodule : mct_pins_model

// file: tb/tb_top.sv
// Purpose: self-checking bench of the counter-timer block
// Assumes: zero-wait apb slave, capture pins driven by the pins model
// Notes: reads queue their expectation, a monitor compares them
`timescale 1ns/100ps
module tb_top;
  import mct_pkg::*;
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] mask;
    logic err;
  } mct_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, go, busy;
  logic [MCT_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] sel;
  logic [7:0] len;
  logic [4:0] cap;
  logic [3:0] m0;
  logic [8:0] mo;
  logic irq_q;
  int miscompares, compares, seed, n, k, i;
  mct_note_s notes[$];
  mct_note_s nt;

  mct_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wide_timer0_capture_in0(cap[0]),
    .wide_timer0_capture_in1(cap[1]), .wide_timer1_capture_in0(cap[2]),
    .narrow_timer0_capture_in0(cap[3]), .narrow_timer1_capture_in0(cap[4]),
    .wide_timer0_match_out0(m0[0]), .wide_timer0_match_out1(m0[1]),
    .wide_timer0_match_out2(m0[2]), .wide_timer0_match_out3(m0[3]),
    .wide_timer1_match_out(mo[8:5]), .narrow_timer0_match_out(mo[4:2]),
    .narrow_timer1_match_out(mo[1:0]));
  mct_pins_model pins_u (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel), .len(len),
    .cap(cap), .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // irq is looked at mid-cycle, away from the edge that launches it
  always @(negedge pclk) begin
    irq_q <= irq;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // one idle cycle after each transfer so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int c;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (pready !== 1'b1) begin
      miscompares++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi,
                    input logic [31:0] mask, input logic err);
    notes.push_back('{lo, hi, mask, err});
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic wait_irq;
    k = 0;
    while (irq_q !== 1'b1 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (irq_q !== 1'b1) begin
      miscompares++;
    end
  endtask : wait_irq

  task automatic pulse(input logic [2:0] s, input logic [7:0] l);
    sel <= s;
    len <= l;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) begin
      @(posedge pclk);
    end
  endtask : pulse

  // ************************************************************
  // monitor: compare each read with the oldest note
  // ************************************************************
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      nt = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
      if (nt.lo == nt.hi) begin
        check("prdata", prdata & nt.mask, nt.lo);
      end else begin
        check("range", {31'h0, prdata >= nt.lo && prdata <= nt.hi}, 32'h1);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 29167;
    miscompares = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = '0;
    pwdata = 32'h00000000;
    sel = 3'h0;
    len = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(12'h100, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(12'h200, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    check("pins", {28'h0, m0}, 32'h0);
    // timer 0: stop on match 0, outputs 0 to 2 act on their own match, output 3 stays
    wr(12'h108, 32'h00000021);
    wr(12'h008, 32'h00000003);
    for (i = 0; i < 4; i++) begin
      wr(12'h014 + 12'(4 * i), 32'h00000005);
    end
    // interrupt on matches 0 and 1, stop on match 0
    wr(12'h010, 32'h0000000D);
    wr(12'h024, 32'h0000039D);
    check("pins", {28'h0, m0}, 32'h0000000D);
    wr(12'h000, 32'h00000001);
    wait_irq();
    wr(12'h004, 32'h00000055);
    repeat (10) @(posedge pclk);
    rd(12'h004, 32'h5, 32'h5, 32'hFFFFFFFF, 1'b0);
    check("pins", {28'h0, m0}, 32'h0000000A);
    rd(12'h100, 32'h3, 32'h3, 32'h000000FF, 1'b0);
    wr(12'h108, 32'h00000000);
    check("irq", {31'h0, irq}, 32'h0);
    wr(12'h108, 32'h00000021);
    check("irq", {31'h0, irq}, 32'h1);
    wr(12'h104, 32'h00000003);
    check("irq", {31'h0, irq}, 32'h0);
    // second capture channel of timer 0 latches the halted count
    wr(12'h028, 32'h00000028);
    pulse(3'h1, 8'h06);
    wait_irq();
    rd(12'h030, 32'h5, 32'h5, 32'hFFFFFFFF, 1'b0);
    rd(12'h100, 32'h20, 32'h20, 32'h000000FF, 1'b0);
    wr(12'h104, 32'h00000020);
    // timer 1: reset on match keeps the count below four
    wr(12'h048, 32'h00000000);
    wr(12'h054, 32'h00000003);
    wr(12'h050, 32'h00000002);
    wr(12'h040, 32'h00000001);
    for (i = 0; i < 6; i++) begin
      repeat ($random(seed) & 7) @(posedge pclk);
      rd(12'h044, 32'h0, 32'h0, 32'hFFFFFFFC, 1'b0);
    end
    // hold-in-reset forces the count to zero
    wr(12'h040, 32'h00000003);
    rd(12'h044, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    // timer 2: clear on leading edge, capture on trailing edge
    n = 16 + ($random(seed) & 15);
    wr(12'h108, 32'h00100000);
    wr(12'h088, 32'h00000000);
    wr(12'h0B4, 32'h00000001);
    wr(12'h0A8, 32'h00000006);
    wr(12'h080, 32'h00000001);
    pulse(3'h3, 8'(n));
    wait_irq();
    rd(12'h0AC, 32'(n - 1), 32'(n + 1), 32'hFFFFFFFF, 1'b0);
    rd(12'h100, 32'h00100000, 32'h00100000, 32'h00FF0000, 1'b0);
    wr(12'h104, 32'h00100000);
    // timer 3: time to reach match 0 at a count of 4 grows with the prescaler terminal
    n = 1 + ($random(seed) & 3);
    wr(12'h108, 32'h01000000);
    wr(12'h0C8, 32'(n));
    wr(12'h0D4, 32'h00000004);
    wr(12'h0D0, 32'h00000001);
    wr(12'h0E4, 32'h00000020);
    wr(12'h0C0, 32'h00000001);
    wait_irq();
    check("period", {31'h0, k >= 4 * (n + 1) - 3 && k <= 4 * (n + 1) + 1}, 32'h1);
    check("outs", {23'h0, mo}, 32'h00000001);
    print_verdict();
  end
endmodule : tb_top
